// ---- hw/tdf_tiling_detect.sv ----
// tiling detection, fence check and surface placement support
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/100ps
module tdf_tiling_detect
  import tdf_pkg::*;
#(
  parameter int PG_W = ADDR_W - PAGE_LSB
) (
  input  wire logic               core_clk,      // 10 MHz core clock
  input  wire logic               rst,           // synchronous reset, active high
  // register port
  input  wire logic [REG_AW-1:0]  reg_addr,      // byte address
  input  wire logic [31:0]        reg_wdata,     // write data
  input  wire logic               reg_we,        // write strobe
  input  wire logic               reg_re,        // read strobe
  output logic [31:0]             reg_rdata,     // read data, cycle after strobe
  // access request
  input  wire logic               acc_valid,     // one-cycle request
  input  wire logic [2:0]         acc_src,       // requesting stream
  input  wire logic [ADDR_W-1:0]  acc_addr,      // pre-tiled linear aperture address
  input  wire logic               surf_tiled,    // descriptor tiled flag
  input  wire logic               surf_walk,     // descriptor walk, 1 = Y-major
  input  wire logic [ADDR_W-1:0]  surf_base,     // descriptor base address
  input  wire logic [PITCH_W-1:0] surf_pitch,    // descriptor pitch in tiles
  input  wire logic [ADDR_W-1:0]  surf_offset,   // x/y derived offset from base
  // access decision
  output logic                    res_valid,     // decision strobe, one cycle
  output logic                    res_tiled,     // apply tiling transform
  output logic                    res_walk,      // 1 = Y-major
  output logic [PITCH_W-1:0]      res_pitch,     // pitch in tiles, zero when linear
  output logic [ADDR_W-1:0]       res_base,      // base added untiled
  output logic [ADDR_W-1:0]       res_offset,    // part that goes through tiling
  output logic                    res_fence_hit, // a fence drove the decision
  output logic                    res_masked,    // a fence matched but was masked
  output logic [FIDX_W-1:0]       res_fence_idx  // fence that matched
);
  // fence and control state
  logic [31:0]           fence_lo_q [NUM_FENCES];
  logic [31:0]           fence_hi_q [NUM_FENCES];
  logic [31:0]           ctrl_q;
  logic [31:0]           row_sel_q;
  // status shown to software
  logic                  st_tiled_q;
  logic                  st_walk_q;
  logic                  st_hit_q;
  logic                  st_mask_q;
  logic [FIDX_W-1:0]     st_idx_q;
  logic [15:0]           st_cnt_q;
  // decode and match
  logic [NUM_FENCES-1:0] hit_vec;
  logic                  any_hit;
  logic [FIDX_W-1:0]     hit_idx;
  logic                  is_host;
  logic                  host_hit;
  logic [FIDX_W-1:0]     reg_fidx;
  logic                  sel_lo;
  logic                  sel_hi;
  logic                  sel_ctrl;
  logic                  sel_status;
  logic                  sel_row_sel;
  logic                  sel_row_addr;
  logic                  cli_mask;
  logic [ADDR_W-1:0]     row_addr;
  logic [FIDX_W-1:0]     row_fidx;
  logic [31:0]           rdata_d;
  // decision next values
  logic                  tiled_d;
  logic                  walk_d;
  logic [PITCH_W-1:0]    pitch_d;
  logic [ADDR_W-1:0]     base_d;
  logic [ADDR_W-1:0]     offset_d;

  function automatic logic [PG_W-1:0] page_of(input logic [31:0] w);
    page_of = w[ADDR_W-1:PAGE_LSB];
  endfunction : page_of

  function automatic logic [PITCH_W-1:0] pitch_of(input logic [31:0] w);
    pitch_of = w[PITCH_LSB +: PITCH_W];
  endfunction : pitch_of

  function automatic logic [ADDR_W-1:0] base_of(input logic [31:0] w);
    base_of = {page_of(w), {PAGE_LSB{1'b0}}};
  endfunction : base_of

  // single-word register decode, shared by the write and the read paths
  function automatic logic reg_is(input logic [REG_AW-1:0] a,
                                  input logic [REG_AW-1:0] off);
    reg_is = (a == off);
  endfunction : reg_is

  // register window decode; each fence word bank is one contiguous span
  assign reg_fidx = reg_addr[FIDX_LSB +: FIDX_W];
  assign sel_lo   = (reg_addr >= REG_FENCE_LO) && (reg_addr < REG_FENCE_LO + FENCE_SPAN);
  assign sel_hi   = (reg_addr >= REG_FENCE_HI) && (reg_addr < REG_FENCE_HI + FENCE_SPAN);
  assign row_fidx = row_sel_q[ROW_FIDX_LSB +: FIDX_W];

  // decoded once so a register cannot be mapped for writes but missed on reads
  assign sel_ctrl     = reg_is(reg_addr, REG_CTRL);
  assign sel_status   = reg_is(reg_addr, REG_STATUS);
  assign sel_row_sel  = reg_is(reg_addr, REG_ROW_SEL);
  assign sel_row_addr = reg_is(reg_addr, REG_ROW_ADDR);

  // one compare per fence register
  for (genvar g = 0; g < NUM_FENCES; g++) begin : g_fence
    tdf_fence_match #(.PG_W(PG_W)) u_match (
      .addr_pg (page_of(acc_addr)),
      .base_pg (page_of(fence_lo_q[g])),
      .last_pg (page_of(fence_hi_q[g])),
      .pitch   (pitch_of(fence_hi_q[g])),
      .enable  (fence_lo_q[g][FENCE_EN_BIT] && ctrl_q[CTRL_EN_BIT]),
      .hit     (hit_vec[g])
    );
  end

  // overlapping fences are a software fault; lowest index wins so the result is defined
  always_comb begin
    any_hit = 1'b0;
    hit_idx = '0;
    for (int i = NUM_FENCES - 1; i >= 0; i--) begin
      if (hit_vec[i]) begin
        any_hit = 1'b1;
        hit_idx = FIDX_W'(i);
      end
    end
  end

  // only the aperture path may see a fence; clients get it masked
  assign is_host  = (acc_src == SRC_HOST);
  assign host_hit = is_host && any_hit;
  // a client inside an enabled fence is only reported; the fence never tiles it
  assign cli_mask = !is_host && any_hit;

  // tiled row start lookup for software placing shared surfaces
  tdf_row_start #(.PG_W(PG_W)) u_row (
    .base_pg  (page_of(fence_lo_q[row_fidx])),
    .pitch    (pitch_of(fence_hi_q[row_fidx])),
    .row      (row_sel_q[ROW_NUM_LSB +: ROW_W]),
    .row_addr (row_addr)
  );

  // classification of the current request
  always_comb begin
    tiled_d  = 1'b0;
    walk_d   = WALK_X;
    pitch_d  = '0;
    base_d   = '0;
    offset_d = acc_addr;
    if (is_host) begin
      if (host_hit) begin
        // whole address tiled as an offset from the fence base
        tiled_d  = 1'b1;
        walk_d   = fence_lo_q[hit_idx][FENCE_WALK_BIT];
        pitch_d  = pitch_of(fence_hi_q[hit_idx]);
        base_d   = base_of(fence_lo_q[hit_idx]);
        offset_d = acc_addr - base_of(fence_lo_q[hit_idx]);
      end else begin
        offset_d = acc_addr;
      end
    end else begin
      // descriptor alone decides; base passes untouched
      base_d   = surf_base;
      offset_d = surf_offset;
      if (surf_tiled) begin
        tiled_d = 1'b1;
        walk_d  = surf_walk;
        pitch_d = surf_pitch;
      end
    end
  end

  // decision outputs, registered one cycle after the request
  always_ff @(posedge core_clk) begin
    if (rst) begin
      res_valid     <= 1'b0;
      res_tiled     <= 1'b0;
      res_walk      <= 1'b0;
      res_pitch     <= '0;
      res_base      <= '0;
      res_offset    <= '0;
      res_fence_hit <= 1'b0;
      res_masked    <= 1'b0;
      res_fence_idx <= '0;
    end else begin
      res_valid <= acc_valid;
      if (acc_valid) begin
        res_tiled     <= tiled_d;
        res_walk      <= walk_d;
        res_pitch     <= pitch_d;
        res_base      <= base_d;
        res_offset    <= offset_d;
        res_fence_hit <= host_hit;
        res_masked    <= cli_mask;
        res_fence_idx <= hit_idx;
      end
    end
  end

  // fence register writes; base and limit are separate words, so software should
  // clear the enable before moving a fence, or a half-updated region may match
  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < NUM_FENCES; i++) begin
        fence_lo_q[i] <= FENCE_RST;
        fence_hi_q[i] <= FENCE_RST;
      end
    end else if (reg_we) begin
      if (sel_lo) begin
        fence_lo_q[reg_fidx] <= reg_wdata;
      end
      if (sel_hi) begin
        fence_hi_q[reg_fidx] <= reg_wdata;
      end
    end
  end

  // control and row select writes
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_q    <= CTRL_RST;
      row_sel_q <= ROW_SEL_RST;
    end else if (reg_we) begin
      if (sel_ctrl) begin
        ctrl_q <= reg_wdata;
      end
      if (sel_row_sel) begin
        row_sel_q <= reg_wdata;
      end
    end
  end

  // last decision and host hit count; the count wraps rather than saturates
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_tiled_q <= 1'b0;
      st_walk_q  <= 1'b0;
      st_hit_q   <= 1'b0;
      st_mask_q  <= 1'b0;
      st_idx_q   <= '0;
      st_cnt_q   <= '0;
    end else if (acc_valid) begin
      st_tiled_q <= tiled_d;
      st_walk_q  <= walk_d;
      st_hit_q   <= host_hit;
      st_mask_q  <= cli_mask;
      st_idx_q   <= hit_idx;
      if (host_hit) begin
        st_cnt_q <= st_cnt_q + 16'h0001;
      end
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rdata_d = '0;
    if (sel_lo) begin
      rdata_d = fence_lo_q[reg_fidx];
    end else if (sel_hi) begin
      rdata_d = fence_hi_q[reg_fidx];
    end else if (sel_ctrl) begin
      rdata_d = ctrl_q;
    end else if (sel_status) begin
      rdata_d[ST_TILED_BIT]              = st_tiled_q;
      rdata_d[ST_WALK_BIT]               = st_walk_q;
      rdata_d[ST_HIT_BIT]                = st_hit_q;
      rdata_d[ST_MASK_BIT]               = st_mask_q;
      rdata_d[ST_IDX_LSB +: FIDX_W]      = st_idx_q;
      rdata_d[ST_CNT_LSB +: 16]          = st_cnt_q;
    end else if (sel_row_sel) begin
      rdata_d = row_sel_q;
    end else if (sel_row_addr) begin
      rdata_d = row_addr;
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (reg_re) begin
      reg_rdata <= rdata_d;
    end else begin
      reg_rdata <= '0;
    end
  end
endmodule : tdf_tiling_detect

// ---- pkg/tdf_pkg.sv ----
// shared constants and types for the tiling detect and fence check block
package tdf_pkg;
  localparam int          NUM_FENCES      = 16;
  localparam int          ADDR_W          = 32;
  localparam int          REG_AW          = 8;
  localparam int          PAGE_LSB        = 12;  // 4KB tile equals one memory page
  localparam int          PITCH_W         = 7;   // pitch counted in tiles
  localparam int          ROW_W           = 16;  // tile row number width
  localparam int          FIDX_W          = 4;
  // register byte offsets
  localparam logic [7:0]  REG_FENCE_LO    = 8'h00;  // fence i base word at 0x00 + 4*i
  localparam logic [7:0]  REG_FENCE_HI    = 8'h40;  // fence i limit word at 0x40 + 4*i
  localparam logic [7:0]  REG_CTRL        = 8'h80;
  localparam logic [7:0]  REG_STATUS      = 8'h84;
  localparam logic [7:0]  REG_ROW_SEL     = 8'h88;
  localparam logic [7:0]  REG_ROW_ADDR    = 8'h8c;
  localparam logic [7:0]  FENCE_SPAN      = 8'h40;  // bytes taken by one fence word bank
  localparam int          FIDX_LSB        = 2;
  // field positions
  localparam int          FENCE_EN_BIT    = 0;
  localparam int          FENCE_WALK_BIT  = 1;
  localparam int          PITCH_LSB       = 0;
  localparam int          CTRL_EN_BIT     = 0;
  localparam int          ST_TILED_BIT    = 0;
  localparam int          ST_WALK_BIT     = 1;
  localparam int          ST_HIT_BIT      = 2;
  localparam int          ST_MASK_BIT     = 3;
  localparam int          ST_IDX_LSB      = 4;
  localparam int          ST_CNT_LSB      = 16;
  localparam int          ROW_FIDX_LSB    = 0;
  localparam int          ROW_NUM_LSB     = 16;
  // reset values
  localparam logic [31:0] CTRL_RST        = 32'h0000_0001;
  localparam logic [31:0] FENCE_RST       = 32'h0000_0000;
  localparam logic [31:0] ROW_SEL_RST     = 32'h0000_0000;

  typedef enum logic [2:0] {
    SRC_HOST    = 3'b000,  // processor through the graphics aperture
    SRC_RENDER  = 3'b001,
    SRC_SAMPLER = 3'b010,
    SRC_BLT     = 3'b011,
    SRC_DISPLAY = 3'b100
  } tdf_src_e;

  typedef enum logic {
    WALK_X = 1'b0,
    WALK_Y = 1'b1
  } tdf_walk_e;
endpackage : tdf_pkg

// ---- hw/tdf_fence_match.sv ----
// one fence region compare against a linear page number
`timescale 1ns/100ps
module tdf_fence_match
  import tdf_pkg::*;
#(
  parameter int PG_W = ADDR_W - PAGE_LSB
) (
  input  wire logic [PG_W-1:0]    addr_pg,   // page of the pre-tiled address
  input  wire logic [PG_W-1:0]    base_pg,   // first page of the fence
  input  wire logic [PG_W-1:0]    last_pg,   // last page of the fence, inclusive
  input  wire logic [PITCH_W-1:0] pitch,     // fence pitch in tiles
  input  wire logic               enable,    // fence enable bit
  output logic                    hit        // address lies inside an enabled fence
);
  function automatic logic in_range(input logic [PG_W-1:0] a,
                                    input logic [PG_W-1:0] lo,
                                    input logic [PG_W-1:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  // a zero pitch cannot describe a tile row, so such a fence never matches
  assign hit = enable && (pitch != '0) && in_range(addr_pg, base_pg, last_pg);
endmodule : tdf_fence_match

// ---- hw/tdf_row_start.sv ----
// tile row start address generator for one fence
`timescale 1ns/100ps
module tdf_row_start
  import tdf_pkg::*;
#(
  parameter int PG_W = ADDR_W - PAGE_LSB
) (
  input  wire logic [PG_W-1:0]    base_pg,   // fence base page
  input  wire logic [PITCH_W-1:0] pitch,     // fence pitch in tiles
  input  wire logic [ROW_W-1:0]   row,       // tile row number
  output logic [ADDR_W-1:0]       row_addr   // tile_row_start_address
);
  logic [ROW_W+PITCH_W-1:0] row_pages;
  logic [PG_W-1:0]          sum_pg;

  // row size is pitch in tiles times one 4KB tile, so work in pages
  assign row_pages = ROW_W'(row) * PITCH_W'(pitch);
  assign sum_pg    = base_pg + PG_W'(row_pages);
  assign row_addr  = {sum_pg, {PAGE_LSB{1'b0}}};
endmodule : tdf_row_start

// ---- verification/tdf_tiling_chk_assertions.sv ----
// concurrent checks on the tiling detect block ports
`timescale 1ns/100ps
module tdf_tiling_chk
  import tdf_pkg::*;
(
  input wire logic               core_clk,      // clock
  input wire logic               rst,           // reset
  input wire logic               acc_valid,     // request
  input wire logic [2:0]         acc_src,       // stream
  input wire logic [ADDR_W-1:0]  acc_addr,      // linear address
  input wire logic               surf_tiled,    // tiled flag
  input wire logic               surf_walk,     // walk
  input wire logic [ADDR_W-1:0]  surf_base,     // base
  input wire logic [PITCH_W-1:0] surf_pitch,    // pitch
  input wire logic [ADDR_W-1:0]  surf_offset,   // offset
  input wire logic               res_valid,     // strobe
  input wire logic               res_tiled,     // tiled
  input wire logic               res_walk,      // walk
  input wire logic [PITCH_W-1:0] res_pitch,     // pitch
  input wire logic [ADDR_W-1:0]  res_base,      // base
  input wire logic [ADDR_W-1:0]  res_offset,    // offset
  input wire logic               res_fence_hit, // hit
  input wire logic               res_masked     // masked
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // request kinds; masked matches are judged only by the bench
  wire cli = acc_valid && acc_src != 3'h0;
  wire hst = acc_valid && acc_src == 3'h0;
  res_pulse_a: assert property (acc_valid |=> res_valid)
    else $error("no decision after request");
  no_spur_a: assert property (!acc_valid |=> !res_valid)
    else $error("decision without request");
  res_hold_a: assert property (!acc_valid |=> $stable(res_tiled) &&
    $stable(res_offset)) else $error("decision changed without request");
  host_fence_a: assert property (hst |=> res_tiled == res_fence_hit)
    else $error("host tiling not from fence");
  cli_base_a: assert property (cli |=> res_base == $past(surf_base) &&
    res_offset == $past(surf_offset) && !res_fence_hit && res_tiled == $past(surf_tiled))
    else $error("client decision not from descriptor");
  cli_mask_a: assert property (cli |=> !res_fence_hit)
    else $error("fence not masked for client");
  cli_walk_a: assert property (cli && surf_tiled |=> res_walk == $past(surf_walk) &&
    res_pitch == $past(surf_pitch)) else $error("client walk or pitch wrong");
  cli_linear_a: assert property (cli && !surf_tiled |=> res_pitch == 7'h00 &&
    !res_walk) else $error("linear client got tiling");
  host_miss_a: assert property (hst |=> res_fence_hit || (res_base == 32'h0 &&
    res_offset == $past(acc_addr))) else $error("host miss not linear");
  host_hit_a: assert property (hst |=> !res_fence_hit || (!res_masked &&
    res_pitch != 7'h00 && res_base + res_offset == $past(acc_addr)))
    else $error("host hit not split at fence base");
  cover property (hst ##1 res_fence_hit);
  cover property (hst ##1 !res_fence_hit);
  cover property (cli ##1 res_masked);
endmodule : tdf_tiling_chk

bind tdf_tiling_detect tdf_tiling_chk chk (.core_clk(core_clk), .rst(rst),
  .acc_valid(acc_valid), .acc_src(acc_src), .acc_addr(acc_addr), .surf_tiled(surf_tiled),
  .surf_walk(surf_walk), .surf_base(surf_base), .surf_pitch(surf_pitch),
  .surf_offset(surf_offset), .res_valid(res_valid), .res_tiled(res_tiled),
  .res_walk(res_walk), .res_pitch(res_pitch), .res_base(res_base), .res_offset(res_offset),
  .res_fence_hit(res_fence_hit), .res_masked(res_masked));

// ---- verification/tdf_req_model.sv ----
// far side model issuing host and client access requests
`timescale 1ns/100ps
module tdf_req_model
  import tdf_pkg::*;
(
  input  wire logic               core_clk,    // clock
  output logic                    acc_valid,   // request pulse
  output logic [2:0]              acc_src,     // stream
  output logic [ADDR_W-1:0]       acc_addr,    // linear address
  output logic                    surf_tiled,  // tiled flag
  output logic                    surf_walk,   // walk
  output logic [ADDR_W-1:0]       surf_base,   // base
  output logic [PITCH_W-1:0]      surf_pitch,  // pitch in tiles
  output logic [ADDR_W-1:0]       surf_offset  // offset
);
  initial begin
    acc_valid = 1'b0;
    {acc_src, acc_addr, surf_tiled, surf_walk, surf_base, surf_pitch, surf_offset} = '0;
  end
  // one request held for one taking edge; address, base and offset then show inverted junk, other fields hold
  task automatic issue(input logic [2:0] src, input logic [ADDR_W-1:0] addr,
    input logic tiled, input logic walk, input logic [PITCH_W-1:0] pitch,
    input logic [ADDR_W-1:0] base, input logic [ADDR_W-1:0] off);
    @(posedge core_clk);
    acc_valid <= 1'b1;
    acc_src <= src;
    acc_addr <= addr;
    surf_tiled <= tiled;
    surf_walk <= walk;
    surf_pitch <= pitch; // pitch counted in whole tiles
    surf_base <= {base[ADDR_W-1:PAGE_LSB], 12'h000}; // page aligned base
    surf_offset <= off;
    @(posedge core_clk);
    acc_valid <= 1'b0;
    acc_addr <= ~addr;
    surf_base <= ~base;
    surf_offset <= ~off;
  endtask : issue
endmodule : tdf_req_model

// ---- verification/tdf_tiling_detect_bench.sv ----
// self-checking bench for the tiling detect block
`timescale 1ns/100ps
module tdf_tiling_detect_bench
  import tdf_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic [31:0] reg_rdata, res_base, res_offset, acc_addr, surf_base, surf_offset, d;
  logic [2:0] acc_src;
  logic [6:0] surf_pitch, res_pitch;
  logic [3:0] res_fence_idx;
  logic acc_valid, surf_tiled, surf_walk, res_valid, res_tiled, res_walk;
  logic res_fence_hit, res_masked;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc_cnt = 0;
  tdf_tiling_detect uut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .acc_valid(acc_valid), .acc_src(acc_src), .acc_addr(acc_addr), .surf_tiled(surf_tiled),
    .surf_walk(surf_walk), .surf_base(surf_base), .surf_pitch(surf_pitch),
    .surf_offset(surf_offset), .res_valid(res_valid), .res_tiled(res_tiled),
    .res_walk(res_walk), .res_pitch(res_pitch), .res_base(res_base), .res_offset(res_offset),
    .res_fence_hit(res_fence_hit), .res_masked(res_masked), .res_fence_idx(res_fence_idx));
  tdf_req_model mdl (.core_clk(core_clk), .acc_valid(acc_valid), .acc_src(acc_src),
    .acc_addr(acc_addr), .surf_tiled(surf_tiled), .surf_walk(surf_walk),
    .surf_base(surf_base), .surf_pitch(surf_pitch), .surf_offset(surf_offset));
  always #50 core_clk = ~core_clk;
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test
  // a hung run counts as a mismatch
  always @(posedge core_clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 3000) begin
      error_cnt++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_we <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_re <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  // compare one decision; the fence index means nothing on a miss
  task automatic expect_res(input logic t, input logic w, input logic [6:0] p,
    input logic [31:0] b, input logic [31:0] o, input logic h, input logic m, input logic [3:0] i);
    #1 chk(res_valid, 1'b1);
    chk({res_tiled, res_walk, res_pitch}, {t, w, p});
    chk(res_base, b);
    chk(res_offset, o);
    chk({res_fence_hit, res_masked}, {h, m});
    if (h) chk(res_fence_idx, i);
  endtask : expect_res
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    rd(REG_CTRL, d);
    chk(d, CTRL_RST);
    rd(REG_FENCE_LO + 8'h0c, d);
    chk(d, FENCE_RST);
    rd(8'h90, d);
    chk(d, 32'h0);
    $display("test reset values done");
    // fence 3: Y walk, pitch 4; fence 15: X walk, pitch 16; host hits both, then misses just past fence 3
    wr(REG_FENCE_LO + 8'h0c, 32'h0010_0003);
    wr(REG_FENCE_HI + 8'h0c, 32'h0010_f004);
    wr(REG_FENCE_LO + 8'h3c, 32'h0080_0001);
    wr(REG_FENCE_HI + 8'h3c, 32'h0080_7010);
    rd(REG_FENCE_HI + 8'h0c, d);
    chk(d, 32'h0010_f004);
    mdl.issue(3'h0, 32'h0010_2345, 1'b0, 1'b0, 7'h0, 32'h0, 32'h0);
    expect_res(1, 1, 7'h04, 32'h0010_0000, 32'h2345, 1, 0, 4'h3);
    mdl.issue(3'h0, 32'h0010_ffff, 1'b0, 1'b0, 7'h0, 32'h0, 32'h0);
    expect_res(1, 1, 7'h04, 32'h0010_0000, 32'h0000_ffff, 1, 0, 4'h3);
    mdl.issue(3'h0, 32'h0080_1008, 1'b0, 1'b0, 7'h0, 32'h0, 32'h0);
    expect_res(1, 0, 7'h10, 32'h0080_0000, 32'h1008, 1, 0, 4'hf);
    mdl.issue(3'h0, 32'h0011_0000, 1'b0, 1'b0, 7'h0, 32'h0, 32'h0);
    expect_res(0, 0, 7'h00, 32'h0, 32'h0011_0000, 0, 0, 4'h0);
    // with the global enable off every fence is ignored
    wr(REG_CTRL, 32'h0);
    mdl.issue(3'h0, 32'h0010_2345, 1'b0, 1'b0, 7'h0, 32'h0, 32'h0);
    expect_res(0, 0, 7'h00, 32'h0, 32'h0010_2345, 0, 0, 4'h0);
    wr(REG_CTRL, CTRL_RST);
    $display("test host fences done");
    // every client stream inside fence 3 must ignore it; widths stay within pitch
    for (int i = 1; i < 5; i++) begin
      mdl.issue(i[2:0], 32'h0010_2345, 1'b1, i[0], 7'h08, 32'h0040_0000, i * 32'h100);
      expect_res(1, i[0], 7'h08, 32'h0040_0000, i * 32'h100, 0, 1, 4'h0);
      chk(res_base, 32'h0040_0000);
    end
    // last client was display inside fence 3: tiled, X walk, masked, three host hits
    rd(REG_STATUS, d);
    chk(d, 32'h0003_0039);
    mdl.issue(3'h2, 32'h0020_0000, 1'b0, 1'b1, 7'h08, 32'h0040_0000, 32'h40);
    expect_res(0, 0, 7'h00, 32'h0040_0000, 32'h40, 0, 0, 4'h0);
    $display("test clients done");
    // row 2 of fence 3 starts two rows of four tiles past the base
    wr(REG_ROW_SEL, 32'h0002_0003);
    rd(REG_ROW_ADDR, d);
    chk(d, 32'h0010_0000 + 2 * 4 * 32'h1000);
    // shared texture placed at that row start, with the fence pitch and walk
    mdl.issue(3'h2, 32'h0010_8040, 1'b1, 1'b1, 7'h04, d, 32'h40);
    expect_res(1, 1, 7'h04, 32'h0010_8000, 32'h40, 0, 1, 4'h0);
    $display("test row start done");
    stop_test();
  end
endmodule : tdf_tiling_detect_bench
